// file: vipb_consts.svh
`ifndef VIPB_CONSTS_SVH
`define VIPB_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define VIPB_ADDR_W          20
`define VIPB_ADDR_CTL        20'he0200
`define VIPB_ADDR_DATA       20'he0208
`define VIPB_ADDR_PAYLOAD    20'he0210

// ----------------------------------------------------------------------------
// packet_control field positions
// ----------------------------------------------------------------------------
`define VIPB_CTL_GCP_EN      25
`define VIPB_CTL_TYPE_HI     24
`define VIPB_CTL_TYPE_LO     21
`define VIPB_CTL_SEL_HI      20
`define VIPB_CTL_SEL_LO      19
`define VIPB_CTL_RATE_HI     17
`define VIPB_CTL_RATE_LO     16
`define VIPB_CTL_CAP_HI      11
`define VIPB_CTL_CAP_LO      8
`define VIPB_CTL_PTR_HI      3
`define VIPB_CTL_PTR_LO      0

// ----------------------------------------------------------------------------
// control_packet_payload field positions
// ----------------------------------------------------------------------------
`define VIPB_PAY_MUTE        0
`define VIPB_PAY_PHASE       1
`define VIPB_PAY_DEPTH       2

// ----------------------------------------------------------------------------
// buffer geometry and fixed values
// ----------------------------------------------------------------------------
`define VIPB_NUM_BUF         4
`define VIPB_BUF_WORDS       9
`define VIPB_MEM_WORDS       36
`define VIPB_CAPACITY        4'h9
`define VIPB_ECC_WORD        4'h8
`define VIPB_ECC_POLY        8'h83
`define VIPB_HDR_BITS        24
`define VIPB_SUB_BITS        56

// ----------------------------------------------------------------------------
// repeat-rate encodings and reset values
// ----------------------------------------------------------------------------
`define VIPB_RATE_ONCE       2'h0
`define VIPB_RATE_EVERY      2'h1
`define VIPB_RATE_OTHER      2'h2
`define VIPB_RST_RATE        2'h0
`define VIPB_RST_SEL         2'h0
`define VIPB_RST_PTR         4'h0

`endif

// file: vipb_pkg.sv
package vipb_pkg;

   // ----------------------------------------------------------------------------
   // buffer select codes
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      VIPB_BUF_AVI    = 2'h0,  // auxiliary video info packet
      VIPB_BUF_VENDOR = 2'h1,  // vendor-specific packet
      VIPB_BUF_GAMUT  = 2'h2,  // gamut metadata packet
      VIPB_BUF_SPD    = 2'h3   // source product description packet
   } vipb_buf_type;

   // ----------------------------------------------------------------------------
   // general control packet fields toward the port
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic set_avmute;     // next packet carries set flag
      logic clear_avmute;   // next packet carries clear flag
      logic default_phase;  // default phase bit
      logic depth_indicate; // colour depth indication
   } vipb_gcp_type;

   // ----------------------------------------------------------------------------
   // whole state of the block
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [35:0][31:0] mem;      // four buffers of nine dwords
      logic [3:0]        ptr;      // word pointer
      vipb_buf_type      sel;      // buffer select
      logic [3:0][1:0]   rate;     // repeat rate per buffer
      logic [1:0]        staged;   // last written repeat rate
      logic [3:0]        type_en;  // packet-type enables
      logic              gcp_en;   // control packet enable
      logic              mute;     // mute control
      vipb_gcp_type      gcp;      // control packet fields
      logic [31:0]       rdata;    // bus read data
      logic [31:0]       pkt_data; // port read data
   } vipb_state_type;

endpackage

// file: vipb_packet_buffer.sv
`timescale 1ns/100ps
// Functional notes
// - buffer select picks AVI, vendor, gamut, SPD
// - rate read returns selected buffer's rate
// - rate codes: once, every, other vsync
// - rate also latched on first dword write
// - capacity field reads fixed maximum size
// - pointer advances after every data access
// - pointer wraps from fifteen to zero
// - pointer write immediate, read shows current
// - data reads return selected word anytime
// - data window moves whole dwords only
// - dword zero header, top byte hardware ECC
// - dword eight holds hardware subpacket ECC
// - phase hint drives default phase bit
// - mute edges flag set or clear once
// - type enables apply at once, unbuffered
`include "vipb_consts.svh"

module vipb_packet_buffer
   import vipb_pkg::*;
(
   input  wire logic                     clk,           // 25 MHz clock
   input  wire logic                     rst,           // synchronous reset
   input  wire logic [`VIPB_ADDR_W-1:0]  reg_addr,      // register byte address
   input  wire logic [31:0]              reg_wdata,     // register write data
   input  wire logic                     reg_we,        // write strobe
   input  wire logic                     reg_re,        // read strobe
   output logic      [31:0]              reg_rdata,     // read data, cycle after strobe
   input  wire logic [1:0]               pkt_rd_sel,    // port: buffer to fetch
   input  wire logic [3:0]               pkt_rd_word,   // port: dword to fetch
   output logic      [31:0]              pkt_rd_data,   // port: fetched dword
   input  wire logic                     gcp_sent,      // port: control packet gone
   output logic      [3:0]               type_enable,   // packet-type enables
   output logic                          gcp_enable,    // control packet enable
   output logic      [7:0]               repeat_rates,  // two bits per buffer
   output vipb_gcp_type                  gcp_fields     // control packet fields
);

   // ----------------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------------

   // full-address compare, no aliasing in the map
   // address hits the data window
   function automatic logic is_data(input logic [`VIPB_ADDR_W-1:0] a);
      return a == `VIPB_ADDR_W'(`VIPB_ADDR_DATA);
   endfunction

   // address hits the control register
   function automatic logic is_ctl(input logic [`VIPB_ADDR_W-1:0] a);
      return a == `VIPB_ADDR_W'(`VIPB_ADDR_CTL);
   endfunction

   // address hits the control packet payload
   function automatic logic is_pay(input logic [`VIPB_ADDR_W-1:0] a);
      return a == `VIPB_ADDR_W'(`VIPB_ADDR_PAYLOAD);
   endfunction

   // bit-serial BCH remainder over the low nbits of d
   // lsb first, right-shift form of the polynomial
   // fixed loop bound so it unrolls; nbits masks the tail
   function automatic logic [7:0] ecc_calc(input logic [55:0] d, input int nbits);
      logic [7:0] e;
      logic       fb;
      e = 8'h00;
      for (int i = 0; i < `VIPB_SUB_BITS; i++) begin
         if (i < nbits) begin
            fb = d[i] ^ e[0];
            e  = {1'b0, e[7:1]};
            if (fb) begin
               e = e ^ `VIPB_ECC_POLY;
            end
         end
      end
      return e;
   endfunction

   // buffer word with hardware ECC merged in, zero outside the buffer
   // ECC is worked out at read time, so it never goes stale
   // against the stored bytes; none of it is kept in the RAM
   function automatic logic [31:0] word_at(input logic [35:0][31:0] m,
                                           input logic [1:0] b,
                                           input logic [3:0] w);
      logic [31:0]  r;
      logic [223:0] d;
      int           base;
      base = int'(b) * `VIPB_BUF_WORDS;
      r    = 32'h0;
      d    = {m[base+7], m[base+6], m[base+5], m[base+4], m[base+3], m[base+2], m[base+1]};
      if (w == 4'h0) begin
         // header bytes plus computed header ECC
         r = {ecc_calc({32'h0, m[base][23:0]}, `VIPB_HDR_BITS), m[base][23:0]};
      end else if (w < `VIPB_ECC_WORD) begin
         // plain payload words
         r = m[base+int'(w)];
      end else if (w == `VIPB_ECC_WORD) begin
         // one ECC byte per seven data bytes
         for (int j = 0; j < 4; j++) begin
            r[8*j +: 8] = ecc_calc(d[56*j +: 56], `VIPB_SUB_BITS);
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   // one packed struct holds every register of the block;
   // the comb process edits a copy, the flop stage stores it
   vipb_state_type s_q;   // registered state
   vipb_state_type s_d;   // next state

   // ----------------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------------
   // strobes never coincide, so writes are decoded first
   // and reads only when no write is present
   always_comb begin
      int idx;
      idx = int'(s_q.sel) * `VIPB_BUF_WORDS + int'(s_q.ptr);
      s_d = s_q;
      // read data stand one cycle only, zero otherwise
      s_d.rdata = 32'h0;

      // port fetch, one cycle latency
      // the port walks the buffers freely, no handshake
      s_d.pkt_data = word_at(s_q.mem, pkt_rd_sel, pkt_rd_word);

      // control packet sent retires pending mute flags
      if (gcp_sent) begin
         s_d.gcp.set_avmute   = 1'b0;
         s_d.gcp.clear_avmute = 1'b0;
      end

      if (reg_we) begin
         if (is_ctl(reg_addr)) begin
            // control register write
            // rate goes straight to the newly selected buffer
            // and is kept for the first dword write as well
            s_d.gcp_en  = reg_wdata[`VIPB_CTL_GCP_EN];
            s_d.type_en = reg_wdata[`VIPB_CTL_TYPE_HI:`VIPB_CTL_TYPE_LO];
            s_d.sel     = vipb_buf_type'(reg_wdata[`VIPB_CTL_SEL_HI:`VIPB_CTL_SEL_LO]);
            s_d.staged  = reg_wdata[`VIPB_CTL_RATE_HI:`VIPB_CTL_RATE_LO];
            s_d.rate[reg_wdata[`VIPB_CTL_SEL_HI:`VIPB_CTL_SEL_LO]] =
               reg_wdata[`VIPB_CTL_RATE_HI:`VIPB_CTL_RATE_LO];
            s_d.ptr     = reg_wdata[`VIPB_CTL_PTR_HI:`VIPB_CTL_PTR_LO];
         end else if (is_data(reg_addr)) begin
            // whole-dword write through the window
            if (s_q.ptr == 4'h0) begin
               // top byte is the hardware header ECC, never stored
               s_d.mem[idx][23:0] = reg_wdata[23:0];
               s_d.rate[s_q.sel]  = s_q.staged;
            end else if (s_q.ptr < `VIPB_ECC_WORD) begin
               s_d.mem[idx] = reg_wdata;
            end
            // ECC word and unused pointer values are not stored
            // the pointer still moves on, so software may stream past
            s_d.ptr = s_q.ptr + 4'h1;
         end else if (is_pay(reg_addr)) begin
            // payload write, mute edges arm one flag
            // rising edge arms set, falling edge arms clear
            // a mute edge written in the cycle of gcp_sent wins over the retire
            s_d.mute               = reg_wdata[`VIPB_PAY_MUTE];
            s_d.gcp.default_phase  = reg_wdata[`VIPB_PAY_PHASE];
            s_d.gcp.depth_indicate = reg_wdata[`VIPB_PAY_DEPTH];
            if (reg_wdata[`VIPB_PAY_MUTE] && !s_q.mute) begin
               s_d.gcp.set_avmute   = 1'b1;
               s_d.gcp.clear_avmute = 1'b0;
            end else if (!reg_wdata[`VIPB_PAY_MUTE] && s_q.mute) begin
               s_d.gcp.clear_avmute = 1'b1;
               s_d.gcp.set_avmute   = 1'b0;
            end
         end
      end else if (reg_re) begin
         if (is_ctl(reg_addr)) begin
            // control readback
            // reserved bits stay zero from the default above
            s_d.rdata[`VIPB_CTL_GCP_EN]                       = s_q.gcp_en;
            s_d.rdata[`VIPB_CTL_TYPE_HI:`VIPB_CTL_TYPE_LO]    = s_q.type_en;
            s_d.rdata[`VIPB_CTL_SEL_HI:`VIPB_CTL_SEL_LO]      = s_q.sel;
            s_d.rdata[`VIPB_CTL_RATE_HI:`VIPB_CTL_RATE_LO]    = s_q.rate[s_q.sel];
            s_d.rdata[`VIPB_CTL_CAP_HI:`VIPB_CTL_CAP_LO]      = `VIPB_CAPACITY;
            s_d.rdata[`VIPB_CTL_PTR_HI:`VIPB_CTL_PTR_LO]      = s_q.ptr;
         end else if (is_data(reg_addr)) begin
            // window read then advance
            // reads move the pointer just as writes do
            s_d.rdata = word_at(s_q.mem, s_q.sel, s_q.ptr);
            s_d.ptr   = s_q.ptr + 4'h1;
         end else if (is_pay(reg_addr)) begin
            // payload readback
            s_d.rdata[`VIPB_PAY_MUTE]  = s_q.mute;
            s_d.rdata[`VIPB_PAY_PHASE] = s_q.gcp.default_phase;
            s_d.rdata[`VIPB_PAY_DEPTH] = s_q.gcp.depth_indicate;
         end
         // unmapped reads return zero
      end
   end

   // ----------------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------------
   // synchronous reset to the idle defaults
   // pointer, select and rates all start at zero
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q        <= '0;
         s_q.sel    <= vipb_buf_type'(`VIPB_RST_SEL);
         s_q.ptr    <= `VIPB_RST_PTR;
         s_q.staged <= `VIPB_RST_RATE;
         s_q.rate   <= {4{`VIPB_RST_RATE}};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------------------------------------------
   // no logic sits between these flops and the pins
   assign reg_rdata    = s_q.rdata;
   assign pkt_rd_data  = s_q.pkt_data;
   assign type_enable  = s_q.type_en;
   assign gcp_enable   = s_q.gcp_en;
   assign repeat_rates = s_q.rate;
   assign gcp_fields   = s_q.gcp;

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   // all checks run on the one clock and rest during reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // data window access moves the pointer by one
   a_ptr_advance: assert property ((reg_we || reg_re) && is_data(reg_addr)
      |=> s_q.ptr == 4'($past(s_q.ptr) + 4'h1))
      else $error("pointer did not advance");

   // top pointer value rolls over to zero
   a_ptr_wrap: assert property (reg_re && is_data(reg_addr) && s_q.ptr == 4'hf
      |=> s_q.ptr == 4'h0)
      else $error("pointer did not wrap");

   // pointer field write lands at the next edge
   a_ptr_write: assert property (reg_we && is_ctl(reg_addr)
      |=> s_q.ptr == $past(reg_wdata[3:0]))
      else $error("pointer write not taken");

   // select field write picks the buffer at once
   a_sel_write: assert property (reg_we && is_ctl(reg_addr)
      |=> s_q.sel == $past(reg_wdata[20:19]))
      else $error("buffer select not taken");

   // capacity is fixed, the reserved bits 15:12 above it read zero
   a_cap_fixed: assert property (reg_re && is_ctl(reg_addr)
      |=> reg_rdata[11:8] == `VIPB_CAPACITY && reg_rdata[15:12] == 4'h0)
      else $error("capacity field wrong");

   // other reserved control bits read zero
   a_ctl_reserved: assert property (reg_re && is_ctl(reg_addr)
      |=> reg_rdata[31:26] == 6'h00 && !reg_rdata[18] && reg_rdata[7:4] == 4'h0)
      else $error("reserved control bits set");

   // rate written is the rate read back
   a_rate_readback: assert property (reg_we && is_ctl(reg_addr) ##1 reg_re && is_ctl(reg_addr)
      |=> reg_rdata[17:16] == $past(reg_wdata[17:16], 2))
      else $error("repeat rate readback wrong");

   // first dword write copies the staged rate
   a_rate_capture: assert property (reg_we && is_data(reg_addr) && s_q.ptr == 4'h0
      |=> s_q.rate[$past(s_q.sel)] == $past(s_q.staged))
      else $error("repeat rate not captured");

   // hardware ECC word is never stored
   a_ecc_protect: assert property (reg_we && is_data(reg_addr) && s_q.ptr >= `VIPB_ECC_WORD
      |=> $stable(s_q.mem))
      else $error("ECC location written");

   // window reads past the ECC word return zero
   a_high_word_zero: assert property (reg_re && is_data(reg_addr) && s_q.ptr > `VIPB_ECC_WORD
      |=> reg_rdata == 32'h0)
      else $error("word past buffer not zero");

   // header ECC byte is kept out of the RAM
   a_hdr_top_byte: assert property (reg_we && is_data(reg_addr) && s_q.ptr == 4'h0
      |=> s_q.mem[$past(int'(s_q.sel)) * `VIPB_BUF_WORDS][31:24] == 8'h00)
      else $error("header ECC byte stored");

   // rising mute edge arms only the set flag
   a_mute_set: assert property (reg_we && is_pay(reg_addr) && reg_wdata[0] && !s_q.mute
      |=> gcp_fields.set_avmute && !gcp_fields.clear_avmute)
      else $error("mute set flag missing");

   // falling mute edge arms only the clear flag
   a_mute_clear: assert property (reg_we && is_pay(reg_addr) && !reg_wdata[0] && s_q.mute
      |=> gcp_fields.clear_avmute && !gcp_fields.set_avmute)
      else $error("mute clear flag missing");

   // set and clear flags never stand together
   a_flag_exclusive: assert property (!(gcp_fields.set_avmute && gcp_fields.clear_avmute))
      else $error("mute flags both set");

   // a sent packet retires the pending flag
   a_flag_retire: assert property (gcp_sent && !(reg_we && is_pay(reg_addr))
      |=> !gcp_fields.set_avmute && !gcp_fields.clear_avmute)
      else $error("mute flag not retired");

   // default phase follows the phase hint
   a_phase_bit: assert property (reg_we && is_pay(reg_addr)
      |=> gcp_fields.default_phase == $past(reg_wdata[1]))
      else $error("default phase wrong");

   // type enables apply with no double buffering
   a_type_enable: assert property (reg_we && is_ctl(reg_addr)
      |=> type_enable == $past(reg_wdata[24:21]))
      else $error("type enable not immediate");

   // control packet enable applies at once
   a_gcp_enable: assert property (reg_we && is_ctl(reg_addr)
      |=> gcp_enable == $past(reg_wdata[25]))
      else $error("control packet enable not immediate");

   // read data stand only after a read strobe
   a_rdata_idle: assert property (!reg_re |=> reg_rdata == 32'h0)
      else $error("read data not cleared");

   // unmapped reads return zero
   a_unmapped_zero: assert property (reg_re && !is_ctl(reg_addr) && !is_data(reg_addr)
      && !is_pay(reg_addr) |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");

   // main scenarios
   c_first_word: cover property (reg_we && is_data(reg_addr) && s_q.ptr == 4'h0);
   c_ecc_read: cover property (reg_re && is_data(reg_addr) && s_q.ptr == `VIPB_ECC_WORD);
   c_mute_cycle: cover property (gcp_fields.set_avmute ##[1:20] gcp_fields.clear_avmute);
   c_ptr_wrap: cover property (s_q.ptr == 4'hf ##1 s_q.ptr == 4'h0);
   c_gcp_retire: cover property (gcp_sent && gcp_fields.clear_avmute);

endmodule

// file: vipb_port_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// port-side model: sweeps every buffer and emits control packets on request
// ----------------------------------------------------------------------------
module vipb_port_model
   import vipb_pkg::*;
(
   input  wire logic        clk,         // system clock
   input  wire logic        rst,         // synchronous reset
   input  wire logic        gcp_enable,  // control packet enable
   input  wire logic        send_gcp,    // bench asks for a control packet
   input  wire logic [3:0]  gap,         // cycles before the packet leaves
   output logic      [1:0]  pkt_rd_sel,  // buffer being fetched
   output logic      [3:0]  pkt_rd_word, // dword being fetched
   input  wire logic [31:0] pkt_rd_data, // fetched dword
   output logic             gcp_sent     // control packet gone
);
   logic [35:0][31:0] cap;    // last dword seen per buffer location
   logic [1:0]        sel_q;  // buffer asked for one cycle back
   logic [3:0]        word_q; // dword asked for one cycle back
   logic [4:0]        wait_q; // countdown to the control packet

   // walk words 0..8 of each buffer in turn, one whole dword per cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pkt_rd_sel  <= 2'h0;
         pkt_rd_word <= 4'h0;
         sel_q       <= 2'h0;
         word_q      <= 4'h0;
         wait_q      <= 5'h00;
         gcp_sent    <= 1'b0;
      end else begin
         sel_q  <= pkt_rd_sel;
         word_q <= pkt_rd_word;
         cap[int'(sel_q) * 9 + int'(word_q)] <= pkt_rd_data;
         if (pkt_rd_word == 4'h8) begin
            pkt_rd_word <= 4'h0;
            pkt_rd_sel  <= pkt_rd_sel + 2'h1;
         end else begin
            pkt_rd_word <= pkt_rd_word + 4'h1;
         end
         // one-cycle pulse, promptly or after a stall
         gcp_sent <= (wait_q == 5'h01) && gcp_enable;
         if (wait_q != 5'h00) begin
            wait_q <= wait_q - 5'h01;
         end else if (send_gcp) begin
            wait_q <= {1'b0, gap} + 5'h01;
         end
      end
   end
endmodule

// file: vipb_packet_buffer_tb_top.sv
`timescale 1ns/100ps
`include "vipb_consts.svh"
module vipb_packet_buffer_tb_top
   import vipb_pkg::*;
;
   typedef struct packed {
      logic        we; // write row, else read row
      logic [19:0] a;  // byte address
      logic [31:0] d;  // write data or expected read data
   } vipb_row_type;

   logic         clk = 1'b0;   // 25 MHz clock
   logic         rst = 1'b1;   // synchronous reset
   logic [19:0]  reg_addr = '0;
   logic [31:0]  reg_wdata = '0;
   logic         reg_we = 1'b0;
   logic         reg_re = 1'b0;
   logic [31:0]  reg_rdata, pkt_rd_data;
   logic [1:0]   pkt_rd_sel;
   logic [3:0]   pkt_rd_word, type_enable, gap = 4'h0;
   logic         gcp_sent, gcp_enable, send_gcp = 1'b0;
   logic [7:0]   repeat_rates;
   vipb_gcp_type gcp_fields;
   int           n_errors = 0, n_checks = 0, cycles = 0;
   vipb_row_type rows [0:16];
   logic [1:0]   rate_tab [0:3];

   always #20 clk = ~clk;

   vipb_packet_buffer vipb_packet_buffer_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pkt_rd_sel(pkt_rd_sel),
      .pkt_rd_word(pkt_rd_word), .pkt_rd_data(pkt_rd_data), .gcp_sent(gcp_sent), .type_enable(type_enable),
      .gcp_enable(gcp_enable), .repeat_rates(repeat_rates), .gcp_fields(gcp_fields));
   vipb_port_model vipb_port_model_i (.clk(clk), .rst(rst), .gcp_enable(gcp_enable), .send_gcp(send_gcp),
      .gap(gap), .pkt_rd_sel(pkt_rd_sel), .pkt_rd_word(pkt_rd_word), .pkt_rd_data(pkt_rd_data),
      .gcp_sent(gcp_sent));

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   // bit-serial remainder, lsb first
   function automatic logic [7:0] ecc(input logic [55:0] v, input int n);
      logic [7:0] r;
      logic       fb;
      r = 8'h00;
      for (int i = 0; i < n; i++) begin
         fb = r[0] ^ v[i];
         r = {1'b0, r[7:1]} ^ (fb ? 8'h83 : 8'h00);
      end
      return r;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [19:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1;
      chk(nm, e, reg_rdata);
   endtask

   // ask the port for a control packet and wait until it has gone
   task automatic send(input logic [3:0] g, input int stand);
      int k;
      k = 0;
      @(posedge clk);
      gap      <= g;
      send_gcp <= 1'b1;
      @(posedge clk);
      send_gcp <= 1'b0;
      #1;
      if (stand > 0) begin
         repeat (stand) @(posedge clk);
         #1;
         chk("flags held", 32'h5, {28'h0, gcp_fields});
      end
      while (gcp_sent !== 1'b1 && k < 40) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk("packet sent", 32'h1, {31'h0, gcp_sent});
      @(posedge clk);
      #1;
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_errors++;
         results();
      end
   end

   // ----------------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------------
   initial begin
      rows = '{'{1'b0, `VIPB_ADDR_CTL, 32'h00000900}, '{1'b1, `VIPB_ADDR_CTL, 32'h000a0000},
         '{1'b0, `VIPB_ADDR_CTL, 32'h000a0900}, '{1'b1, `VIPB_ADDR_DATA, 32'hff332211},
         '{1'b1, `VIPB_ADDR_DATA, 32'h44434241}, '{1'b0, `VIPB_ADDR_CTL, 32'h000a0902},
         '{1'b1, `VIPB_ADDR_CTL, 32'h000a0008}, '{1'b1, `VIPB_ADDR_DATA, 32'h12345678},
         '{1'b1, `VIPB_ADDR_CTL, 32'h000a0000}, '{1'b0, `VIPB_ADDR_DATA, {ecc(56'h332211, 24), 24'h332211}},
         '{1'b0, `VIPB_ADDR_DATA, 32'h44434241}, '{1'b1, `VIPB_ADDR_CTL, 32'h000a0008},
         '{1'b0, `VIPB_ADDR_DATA, {24'h0, ecc(56'h44434241, 56)}}, '{1'b0, `VIPB_ADDR_CTL, 32'h000a0909},
         '{1'b0, 20'he0204, 32'h0}, '{1'b1, 20'he0204, 32'hffffffff}, '{1'b0, `VIPB_ADDR_CTL, 32'h000a0909}};
      rate_tab = '{2'h1, 2'h2, 2'h0, 2'h1};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // table of register accesses
      for (int i = 0; i < 17; i++) begin
         if (rows[i].we) wr(rows[i].a, rows[i].d);
         else rd(rows[i].a, rows[i].d, $sformatf("row %0d", i));
      end
      $display("test table done");
      // every buffer code and rate code; first dword write latches the rate
      for (int s = 0; s < 4; s++) begin
         wr(`VIPB_ADDR_CTL, {11'h0, 2'(s), 1'b0, rate_tab[s], 16'h0});
         wr(`VIPB_ADDR_DATA, 32'(s + 1));
         rd(`VIPB_ADDR_CTL, {11'h0, 2'(s), 1'b0, rate_tab[s], 16'h0901}, "select rate");
      end
      chk("rates", 32'h49, {24'h0, repeat_rates});
      repeat (40) @(posedge clk);
      for (int s = 0; s < 4; s++) begin
         chk("port header", 32'(s + 1), {8'h0, vipb_port_model_i.cap[s * 9][23:0]});
      end
      $display("test buffers done");
      // pointer wraps from the top word back to zero
      wr(`VIPB_ADDR_CTL, 32'h0000000f);
      rd(`VIPB_ADDR_DATA, 32'h0, "word 15");
      rd(`VIPB_ADDR_CTL, 32'h00000900, "wrap");
      $display("test wrap done");
      // type enables apply at once
      for (int i = 0; i < 4; i++) begin
         wr(`VIPB_ADDR_CTL, 32'h1 << (21 + i));
         chk("type enable", 32'h1 << i, {28'h0, type_enable});
      end
      wr(`VIPB_ADDR_CTL, 32'h02000000);
      chk("gcp enable", 32'h1, {31'h0, gcp_enable});
      // mute edges, phase hint and depth
      wr(`VIPB_ADDR_PAYLOAD, 32'h3);
      chk("mute set", 32'ha, {28'h0, gcp_fields});
      send(4'h0, 0);
      chk("set retired", 32'h2, {28'h0, gcp_fields});
      wr(`VIPB_ADDR_PAYLOAD, 32'h4);
      chk("mute clear", 32'h5, {28'h0, gcp_fields});
      send(4'h9, 5);
      chk("clear retired", 32'h1, {28'h0, gcp_fields});
      wr(`VIPB_ADDR_PAYLOAD, 32'h4);
      chk("no edge", 32'h1, {28'h0, gcp_fields});
      $display("test control packet done");
      // reset in mid-run
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("outputs", 32'h0, {15'h0, type_enable, gcp_enable, repeat_rates, gcp_fields});
      rd(`VIPB_ADDR_CTL, 32'h00000900, "after reset");
      $display("test reset done");
      results();
   end
endmodule
